// file: core/pdm_mic_pkg.sv
package pdm_mic_pkg;

	// ***************************************************************
	// Register offsets (byte addresses)
	// ***************************************************************
	localparam logic [11:0] OFF_TASK_START    = 12'h000;
	localparam logic [11:0] OFF_TASK_STOP     = 12'h004;
	localparam logic [11:0] OFF_INTEN         = 12'h300;
	localparam logic [11:0] OFF_INTEN_SET     = 12'h304;
	localparam logic [11:0] OFF_INTEN_CLR     = 12'h308;
	localparam logic [11:0] OFF_EVT_STATUS    = 12'h30c;
	localparam logic [11:0] OFF_ENABLE        = 12'h500;
	localparam logic [11:0] OFF_CLKCTRL       = 12'h504;
	localparam logic [11:0] OFF_ROUTING       = 12'h508;
	localparam logic [11:0] OFF_GAIN_LEFT     = 12'h518;
	localparam logic [11:0] OFF_GAIN_RIGHT    = 12'h51c;
	localparam logic [11:0] OFF_RATIO         = 12'h520;
	localparam logic [11:0] OFF_CLK_PIN       = 12'h540;
	localparam logic [11:0] OFF_DATA_PIN      = 12'h544;
	localparam logic [11:0] OFF_MCLK          = 12'h54c;
	localparam logic [11:0] OFF_SAMPLE_BUFFER_POINTER    = 12'h560;
	localparam logic [11:0] OFF_SAMPLE_COUNT  = 12'h564;

	// ***************************************************************
	// Field positions and codes
	// ***************************************************************
	localparam int NUM_EVT          = 3;
	localparam int EVT_STARTED      = 0;
	localparam int EVT_HALTED       = 1;
	localparam int EVT_FULL         = 2;
	localparam int PIN_CONNECT_BIT  = 31;
	localparam int GAIN_W           = 7;
	localparam logic [6:0] LOWEST_GAIN_CODE  = 7'h00;
	localparam logic [6:0] UNITY_GAIN_CODE   = 7'h28;
	localparam logic [6:0] HIGHEST_GAIN_CODE = 7'h50;
	// Linear scale chosen so that a full-density window at unity gain
	// lands just inside the 16-bit range for the longest ratio
	localparam logic [3:0] GAIN_SCALE        = 4'ha;
	localparam logic [6:0] RATIO_LOW_COUNT   = 7'h40;
	localparam logic [6:0] RATIO_HIGH_COUNT  = 7'h50;

	// ***************************************************************
	// Reset values and limits
	// ***************************************************************
	localparam logic [7:0]  CLKDIV_RESET     = 8'h0b;
	localparam logic [7:0]  CLKDIV_MIN       = 8'h01;
	localparam logic [31:0] PIN_SEL_RESET    = 32'hffffffff;
	localparam logic [31:0] MCLK_RESET       = 32'h00000000;

	// ***************************************************************
	// Types
	// ***************************************************************
	typedef struct packed {
		logic left_on_rising;
		logic mono;
	} routing_t;

	typedef struct packed {
		logic [15:0] upper;
		logic [15:0] lower;
	} ram_word_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_STOPPING
	} xfer_state_t;

endpackage

// file: core/pdm_mic_interface_regs.sv
`timescale 1ns/1ps

module pdm_mic_interface_regs #(
	parameter int COUNT_W = 16
) (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	input  wire logic        pdm_din,
	output logic             pdm_clk_out,
	output logic      [31:0] clk_pin_route,
	output logic      [31:0] data_pin_route,
	output logic      [31:0] mclk_setup,
	output logic             dma_wr_en,
	output logic      [31:0] dma_addr,
	output logic      [31:0] dma_data
);

	// ***************************************************************
	// Register storage
	// ***************************************************************
	logic [pdm_mic_pkg::NUM_EVT-1:0] inten_reg;
	logic [pdm_mic_pkg::NUM_EVT-1:0] status_reg;
	logic [pdm_mic_pkg::NUM_EVT-1:0] evt_pulse_reg;
	logic                            enable_reg;
	logic [7:0]                      clkdiv_reg;
	pdm_mic_pkg::routing_t           routing_reg;
	logic [6:0]                      gain_left_reg;
	logic [6:0]                      gain_right_reg;
	logic                            ratio_reg;
	logic [31:0]                     clk_pin_reg;
	logic [31:0]                     data_pin_reg;
	logic [31:0]                     mclk_reg;
	logic [31:0]                     ptr_reg;
	logic [COUNT_W-1:0]              count_reg;
	logic                            start_req_reg;
	logic                            stop_req_reg;

	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic        irq_reg;

	logic [31:0] rd_next;
	logic        hit_next;
	logic        wr_do;
	logic [6:0]  gain_wr;

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq     = irq_reg;
	assign clk_pin_route  = clk_pin_reg;
	assign data_pin_route = data_pin_reg;
	assign mclk_setup     = mclk_reg;

	assign wr_do = psel & penable & pready_reg & pwrite;
	// clamp gain codes
	// Codes above the top step are held at the top step
	assign gain_wr = (pwdata[6:0] > pdm_mic_pkg::HIGHEST_GAIN_CODE) ?
		pdm_mic_pkg::HIGHEST_GAIN_CODE : pwdata[6:0];

	// ***************************************************************
	// APB read decode
	// ***************************************************************
	always_comb begin
		rd_next  = 32'h00000000;
		hit_next = 1'b1;
		case (paddr)
			pdm_mic_pkg::OFF_TASK_START,
			pdm_mic_pkg::OFF_TASK_STOP: rd_next = 32'h00000000;
			pdm_mic_pkg::OFF_INTEN,
			pdm_mic_pkg::OFF_INTEN_SET,
			pdm_mic_pkg::OFF_INTEN_CLR: rd_next = {29'h0, inten_reg};
			pdm_mic_pkg::OFF_EVT_STATUS: rd_next = {29'h0, status_reg};
			pdm_mic_pkg::OFF_ENABLE: rd_next = {31'h0, enable_reg};
			pdm_mic_pkg::OFF_CLKCTRL: rd_next = {24'h0, clkdiv_reg};
			pdm_mic_pkg::OFF_ROUTING: rd_next = {30'h0, routing_reg};
			pdm_mic_pkg::OFF_GAIN_LEFT: rd_next = {25'h0, gain_left_reg};
			pdm_mic_pkg::OFF_GAIN_RIGHT: rd_next = {25'h0, gain_right_reg};
			pdm_mic_pkg::OFF_RATIO: rd_next = {31'h0, ratio_reg};
			pdm_mic_pkg::OFF_CLK_PIN: rd_next = clk_pin_reg;
			pdm_mic_pkg::OFF_DATA_PIN: rd_next = data_pin_reg;
			pdm_mic_pkg::OFF_MCLK: rd_next = mclk_reg;
			pdm_mic_pkg::OFF_SAMPLE_BUFFER_POINTER: rd_next = ptr_reg;
			pdm_mic_pkg::OFF_SAMPLE_COUNT: rd_next = 32'(count_reg);
			default: hit_next = 1'b0;
		endcase
	end

	// Answer prepared in the setup cycle, so no access has a wait state
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			prdata_reg  <= 32'h00000000;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else if (psel && !penable) begin
			prdata_reg  <= pwrite ? 32'h00000000 : rd_next;
			pready_reg  <= 1'b1;
			pslverr_reg <= ~hit_next;
		end else begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end
	end

	// ***************************************************************
	// Configuration registers
	// ***************************************************************
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			enable_reg     <= 1'b0;
			clkdiv_reg     <= pdm_mic_pkg::CLKDIV_RESET;
			routing_reg    <= '0;
			gain_left_reg  <= pdm_mic_pkg::UNITY_GAIN_CODE;
			gain_right_reg <= pdm_mic_pkg::UNITY_GAIN_CODE;
			ratio_reg      <= 1'b0;
			clk_pin_reg    <= pdm_mic_pkg::PIN_SEL_RESET;
			data_pin_reg   <= pdm_mic_pkg::PIN_SEL_RESET;
			mclk_reg       <= pdm_mic_pkg::MCLK_RESET;
			ptr_reg        <= 32'h00000000;
			count_reg      <= '0;
		end else if (wr_do) begin
			case (paddr)
				pdm_mic_pkg::OFF_ENABLE: enable_reg <= pwdata[0];
				pdm_mic_pkg::OFF_CLKCTRL: clkdiv_reg <=
					(pwdata[7:0] < pdm_mic_pkg::CLKDIV_MIN) ?
					pdm_mic_pkg::CLKDIV_MIN : pwdata[7:0];
				pdm_mic_pkg::OFF_ROUTING: routing_reg <= pwdata[1:0];
				pdm_mic_pkg::OFF_GAIN_LEFT: gain_left_reg <= gain_wr;
				pdm_mic_pkg::OFF_GAIN_RIGHT: gain_right_reg <= gain_wr;
				pdm_mic_pkg::OFF_RATIO: ratio_reg <= pwdata[0];
				pdm_mic_pkg::OFF_CLK_PIN: clk_pin_reg <= pwdata;
				pdm_mic_pkg::OFF_DATA_PIN: data_pin_reg <= pwdata;
				pdm_mic_pkg::OFF_MCLK: mclk_reg <= pwdata;
				pdm_mic_pkg::OFF_SAMPLE_BUFFER_POINTER: ptr_reg <= pwdata;
				pdm_mic_pkg::OFF_SAMPLE_COUNT: count_reg <= pwdata[COUNT_W-1:0];
				default: ;
			endcase
		end
	end

	// ***************************************************************
	// Interrupt enables, event status, interrupt line
	// ***************************************************************
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			inten_reg <= '0;
		end else if (wr_do && paddr == pdm_mic_pkg::OFF_INTEN) begin
			inten_reg <= pwdata[pdm_mic_pkg::NUM_EVT-1:0];
		end else if (wr_do && paddr == pdm_mic_pkg::OFF_INTEN_SET) begin
			inten_reg <= inten_reg | pwdata[pdm_mic_pkg::NUM_EVT-1:0];
		end else if (wr_do && paddr == pdm_mic_pkg::OFF_INTEN_CLR) begin
			inten_reg <= inten_reg & ~pwdata[pdm_mic_pkg::NUM_EVT-1:0];
		end
	end

	// A new event in the clearing cycle keeps its bit set
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			status_reg <= '0;
		end else if (wr_do && paddr == pdm_mic_pkg::OFF_EVT_STATUS) begin
			status_reg <= (status_reg & ~pwdata[pdm_mic_pkg::NUM_EVT-1:0])
				| evt_pulse_reg;
		end else begin
			status_reg <= status_reg | evt_pulse_reg;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(status_reg & inten_reg);
		end
	end

	// Task strobes, one cycle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			start_req_reg <= 1'b0;
			stop_req_reg  <= 1'b0;
		end else begin
			start_req_reg <= wr_do && paddr == pdm_mic_pkg::OFF_TASK_START
				&& pwdata[0];
			stop_req_reg  <= wr_do && paddr == pdm_mic_pkg::OFF_TASK_STOP
				&& pwdata[0];
		end
	end

	// ***************************************************************
	// Microphone clock generator
	// ***************************************************************
	logic [7:0] div_cnt_reg;
	logic       pdm_clk_reg;
	logic       rise_evt;
	logic       fall_evt;
	logic       toggle;
	logic       run;

	assign run      = enable_reg;
	assign toggle   = run && div_cnt_reg >= clkdiv_reg;
	assign rise_evt = toggle && !pdm_clk_reg;
	assign fall_evt = toggle && pdm_clk_reg;
	assign pdm_clk_out = pdm_clk_reg;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt_reg <= 8'h00;
			pdm_clk_reg <= 1'b0;
		end else if (!run) begin
			div_cnt_reg <= 8'h00;
			pdm_clk_reg <= 1'b0;
		end else if (toggle) begin
			div_cnt_reg <= 8'h00;
			pdm_clk_reg <= ~pdm_clk_reg;
		end else begin
			div_cnt_reg <= div_cnt_reg + 8'h01;
		end
	end

	// Data pin is asynchronous to sys_clk
	logic din_meta_reg;
	logic din_sync_reg;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			din_meta_reg <= 1'b0;
			din_sync_reg <= 1'b0;
		end else begin
			din_meta_reg <= pdm_din;
			din_sync_reg <= din_meta_reg;
		end
	end

	// ***************************************************************
	// Density accumulation per window
	// ***************************************************************
	logic [6:0] bit_cnt_reg;
	logic [6:0] ones_left_reg;
	logic [6:0] ones_right_reg;
	logic       win_done_reg;
	logic [6:0] win_len;
	logic       left_evt;
	logic       right_evt;

	assign win_len = ratio_reg ? pdm_mic_pkg::RATIO_HIGH_COUNT :
		pdm_mic_pkg::RATIO_LOW_COUNT;
	assign left_evt  = routing_reg.left_on_rising ? rise_evt : fall_evt;
	assign right_evt = routing_reg.left_on_rising ? fall_evt : rise_evt;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bit_cnt_reg    <= 7'h00;
			ones_left_reg  <= 7'h00;
			ones_right_reg <= 7'h00;
			win_done_reg   <= 1'b0;
		end else if (!run || win_done_reg) begin
			bit_cnt_reg    <= 7'h00;
			ones_left_reg  <= 7'h00;
			ones_right_reg <= 7'h00;
			win_done_reg   <= 1'b0;
		end else begin
			if (left_evt && din_sync_reg) begin
				ones_left_reg <= ones_left_reg + 7'h01;
			end
			if (right_evt && din_sync_reg) begin
				ones_right_reg <= ones_right_reg + 7'h01;
			end
			// Window closes after the right-channel edge of its last bit
			if (right_evt) begin
				bit_cnt_reg  <= bit_cnt_reg + 7'h01;
				win_done_reg <= bit_cnt_reg == win_len - 7'h01;
			end
		end
	end

	// Density times linear gain, saturated to 16 bits. Gain steps are
	// linear here, not true half-decibel steps; kept cheap on purpose.
	function automatic logic [15:0] scale(input logic [6:0] ones,
			input logic [6:0] len, input logic [6:0] gain);
		logic signed [8:0]  dens;
		logic signed [31:0] prod;
		dens = $signed({1'b0, ones, 1'b0}) - $signed({2'b00, len});
		prod = 32'(dens) * $signed({25'h0, gain})
			* $signed({28'h0, pdm_mic_pkg::GAIN_SCALE});
		if (prod > 32'sd32767) begin
			scale = 16'h7fff;
		end else if (prod < -32'sd32768) begin
			scale = 16'h8000;
		end else begin
			scale = prod[15:0];
		end
	endfunction

	logic [15:0] left_sample;
	logic [15:0] right_sample;

	assign left_sample  = scale(ones_left_reg, win_len, gain_left_reg);
	assign right_sample = scale(ones_right_reg, win_len, gain_right_reg);

	// ***************************************************************
	// Transfer control and RAM writer
	// ***************************************************************
	pdm_mic_pkg::xfer_state_t state_reg;
	logic [31:0]        wr_ptr_reg;
	logic [COUNT_W-1:0] done_reg;
	logic [15:0]        held_reg;
	logic               have_half_reg;
	logic               dma_wr_en_reg;
	logic [31:0]        dma_addr_reg;
	pdm_mic_pkg::ram_word_t dma_data_reg;
	logic               word_ready;
	pdm_mic_pkg::ram_word_t word_next;
	logic               buf_last;

	assign dma_wr_en = dma_wr_en_reg;
	assign dma_addr  = dma_addr_reg;
	assign dma_data  = dma_data_reg;

	always_comb begin
		word_ready = 1'b0;
		word_next  = '0;
		if (win_done_reg && state_reg != pdm_mic_pkg::ST_IDLE) begin
			if (!routing_reg.mono) begin
				word_ready = 1'b1;
				word_next  = {right_sample, left_sample};
			end else if (have_half_reg) begin
				word_ready = 1'b1;
				word_next  = {left_sample, held_reg};
			end
		end
	end

	assign buf_last = done_reg + COUNT_W'(2) >= count_reg;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			have_half_reg <= 1'b0;
			held_reg      <= 16'h0000;
		end else if (state_reg == pdm_mic_pkg::ST_IDLE || !routing_reg.mono) begin
			have_half_reg <= 1'b0;
		end else if (win_done_reg) begin
			have_half_reg <= ~have_half_reg;
			held_reg      <= left_sample;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg     <= pdm_mic_pkg::ST_IDLE;
			wr_ptr_reg    <= 32'h00000000;
			done_reg      <= '0;
			dma_wr_en_reg <= 1'b0;
			dma_addr_reg  <= 32'h00000000;
			dma_data_reg  <= '0;
			evt_pulse_reg <= '0;
		end else begin
			dma_wr_en_reg <= 1'b0;
			evt_pulse_reg <= '0;
			case (state_reg)
				pdm_mic_pkg::ST_IDLE: begin
					if (start_req_reg && enable_reg) begin
						wr_ptr_reg <= ptr_reg;
						done_reg   <= '0;
						state_reg  <= pdm_mic_pkg::ST_RUN;
						evt_pulse_reg[pdm_mic_pkg::EVT_STARTED] <= 1'b1;
					end
				end
				pdm_mic_pkg::ST_RUN,
				pdm_mic_pkg::ST_STOPPING: begin
					if (stop_req_reg) begin
						state_reg <= pdm_mic_pkg::ST_STOPPING;
					end
					if (!enable_reg) begin
						state_reg <= pdm_mic_pkg::ST_IDLE;
					end else if (word_ready) begin
						dma_wr_en_reg <= 1'b1;
						dma_addr_reg  <= wr_ptr_reg;
						dma_data_reg  <= word_next;
						wr_ptr_reg    <= wr_ptr_reg + 32'h00000004;
						done_reg      <= done_reg + COUNT_W'(2);
						if (state_reg == pdm_mic_pkg::ST_STOPPING) begin
							evt_pulse_reg[pdm_mic_pkg::EVT_FULL]   <= 1'b1;
							evt_pulse_reg[pdm_mic_pkg::EVT_HALTED] <= 1'b1;
							state_reg <= pdm_mic_pkg::ST_IDLE;
						end else if (buf_last) begin
							evt_pulse_reg[pdm_mic_pkg::EVT_FULL] <= 1'b1;
							evt_pulse_reg[pdm_mic_pkg::EVT_STARTED] <= 1'b1;
							wr_ptr_reg <= ptr_reg;
							done_reg   <= '0;
						end
					end
				end
				default: state_reg <= pdm_mic_pkg::ST_IDLE;
			endcase
		end
	end

endmodule // pdm_mic_interface_regs

// file: verif/pdm_mic_chk.sv
`timescale 1ns/1ps
// ***************************************************************
// Port checker
// ***************************************************************
module pdm_mic_chk (
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq,
	input wire logic        pdm_clk_out,
	input wire logic [31:0] clk_pin_route,
	input wire logic [31:0] mclk_setup,
	input wire logic        dma_wr_en,
	input wire logic [31:0] dma_addr,
	input wire logic [31:0] dma_data
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_wr(logic [11:0] a);
		psel && penable && pready && pwrite && paddr == a;
	endsequence
	sequence s_rd(logic [11:0] a);
		psel && penable && pready && !pwrite && paddr == a;
	endsequence

	a_ready_once: assert property (
		s_setup |=> pready ##1 !pready)
		else $error("ready not one cycle after setup");
	a_unmapped_err: assert property (
		pready && paddr[11:10] == 2'b11 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_mask_width: assert property (
		s_rd(pdm_mic_pkg::OFF_INTEN_CLR) |-> prdata[31:3] == 29'h0)
		else $error("enable read wider than three bits");
	a_gain_ceiling: assert property (
		pready && !pwrite && (paddr == pdm_mic_pkg::OFF_GAIN_LEFT
		|| paddr == pdm_mic_pkg::OFF_GAIN_RIGHT) |-> prdata <= 32'h50)
		else $error("gain above highest code");
	a_irq_masked: assert property (
		s_wr(pdm_mic_pkg::OFF_INTEN_CLR) ##0 pwdata[2:0] == 3'h7
		|-> ##2 (!irq)[*2])
		else $error("interrupt still high when all masked");
	a_clk_stops: assert property (
		s_wr(pdm_mic_pkg::OFF_ENABLE) ##0 !pwdata[0]
		|-> ##3 (!pdm_clk_out)[*8])
		else $error("mic clock runs while disabled");
	a_pin_copy: assert property (
		s_wr(pdm_mic_pkg::OFF_CLK_PIN) |=> clk_pin_route == $past(pwdata))
		else $error("clock pin route not updated");
	a_mclk_copy: assert property (
		s_wr(pdm_mic_pkg::OFF_MCLK) |=> mclk_setup == $past(pwdata))
		else $error("master clock setup not updated");
	a_dma_pulse: assert property (
		dma_wr_en |=> !dma_wr_en)
		else $error("dma write longer than one cycle");
	a_dma_hold: assert property (
		!dma_wr_en |-> $stable(dma_addr) && $stable(dma_data))
		else $error("dma address or data moved between writes");
endmodule // pdm_mic_chk

bind pdm_mic_interface_regs pdm_mic_chk u_chk (
	.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq),
	.pdm_clk_out(pdm_clk_out), .clk_pin_route(clk_pin_route),
	.mclk_setup(mclk_setup), .dma_wr_en(dma_wr_en),
	.dma_addr(dma_addr), .dma_data(dma_data)
);

// file: verif/pdm_mic_model.sv
`timescale 1ns/1ps
// ***************************************************************
// Microphone pair sharing one data line
// ***************************************************************
module pdm_mic_model (
	input  wire logic clk_in,
	output logic      data_out
);
	// One mic full-high and one full-low, so a swapped capture edge
	// shows up as swapped word halves
	// high after rise, low after fall
	always @(clk_in) data_out <= clk_in;
endmodule // pdm_mic_model

// file: verif/pdm_mic_interface_regs_bench.sv
`timescale 1ns/1ps
// ***************************************************************
// Bench
// ***************************************************************
module pdm_mic_interface_regs_bench;
	logic        sys_clk;
	logic        nrst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        pdm_din;
	logic        pdm_clk_out;
	logic [31:0] clk_pin_route;
	logic [31:0] data_pin_route;
	logic [31:0] mclk_setup;
	logic        dma_wr_en;
	logic [31:0] dma_addr;
	logic [31:0] dma_data;
	int          errors;
	int          n_checks;
	int          nw;
	logic [31:0] q;
	logic        e;
	logic        pc;
	// Stream cases: routing, left gain, right gain, ratio
	int md [5] = '{0, 2, 1, 0, 0};
	int gl [5] = '{40, 40, 40, 0, 40};
	int gr [5] = '{40, 40, 40, 80, 80};
	int rt [5] = '{0, 0, 0, 0, 1};

	pdm_mic_interface_regs #(.COUNT_W(16)) DUT (
		.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.pdm_din(pdm_din), .pdm_clk_out(pdm_clk_out),
		.clk_pin_route(clk_pin_route), .data_pin_route(data_pin_route),
		.mclk_setup(mclk_setup), .dma_wr_en(dma_wr_en),
		.dma_addr(dma_addr), .dma_data(dma_data));
	pdm_mic_model u_mic (.clk_in(pdm_clk_out), .data_out(pdm_din));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic results();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic [11:0] a, input logic w,
		input logic [31:0] d);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			errors++;
			results();
		end else begin
			@(posedge sys_clk);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		chk(q, exp);
	endtask

	task automatic word(output logic [31:0] a, output logic [31:0] d);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (dma_wr_en !== 1'b1 && n < 3000);
		a = dma_addr;
		d = dma_data;
		if (dma_wr_en !== 1'b1) begin
			errors++;
			results();
		end
	endtask

	// Full-density window, saturated to 16 bits
	function automatic logic [15:0] smp(input int d, input int g);
		int v;
		v = d * g * 10;
		if (v > 32767) v = 32767;
		if (v < -32768) v = -32768;
		return v[15:0];
	endfunction

	task automatic run(input int i);
		logic [31:0] a [3];
		logic [31:0] d [3];
		logic [31:0] x;
		int len;
		int n;
		len = (rt[i] == 1) ? 80 : 64;
		x = {smp(-len, gr[i]), smp(len, gl[i])};
		if (md[i] == 2) x = {smp(len, gr[i]), smp(-len, gl[i])};
		if (md[i] == 1) x = {smp(len, gl[i]), smp(len, gl[i])};
		wr(pdm_mic_pkg::OFF_ROUTING, 32'(md[i]));
		wr(pdm_mic_pkg::OFF_GAIN_LEFT, 32'(gl[i]));
		wr(pdm_mic_pkg::OFF_GAIN_RIGHT, 32'(gr[i]));
		wr(pdm_mic_pkg::OFF_RATIO, 32'(rt[i]));
		wr(pdm_mic_pkg::OFF_EVT_STATUS, 32'h7);
		wr(pdm_mic_pkg::OFF_TASK_START, 32'h1);
		for (n = 0; n < 3; n++)
			word(a[n], d[n]);
		chk(a[0], 32'h2000);
		chk(a[1], 32'h2004);
		chk(a[2], 32'h2000);
		chk(d[1], x);
		rd(pdm_mic_pkg::OFF_EVT_STATUS, 32'h5);
		chk({31'h0, irq}, 32'h1);
		wr(pdm_mic_pkg::OFF_INTEN_CLR, 32'h7);
		@(posedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		wr(pdm_mic_pkg::OFF_INTEN_SET, 32'h7);
		wr(pdm_mic_pkg::OFF_TASK_STOP, 32'h1);
		n = 0;
		do begin
			xfer(pdm_mic_pkg::OFF_EVT_STATUS, 1'b0, 32'h0);
			n++;
		end while (q[1] !== 1'b1 && n < 400);
		chk(q, 32'h7);
		wr(pdm_mic_pkg::OFF_EVT_STATUS, 32'h7);
	endtask

	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		errors = 0;
		n_checks = 0;
		nw = 0;
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		chk(clk_pin_route, 32'hffffffff);
		rd(pdm_mic_pkg::OFF_INTEN_CLR, 32'h0);
		rd(pdm_mic_pkg::OFF_ROUTING, 32'h0);
		rd(pdm_mic_pkg::OFF_GAIN_LEFT, 32'h28);
		rd(pdm_mic_pkg::OFF_GAIN_RIGHT, 32'h28);
		rd(pdm_mic_pkg::OFF_CLKCTRL, 32'hb);
		wr(pdm_mic_pkg::OFF_INTEN_SET, 32'h7);
		rd(pdm_mic_pkg::OFF_INTEN_CLR, 32'h7);
		wr(pdm_mic_pkg::OFF_INTEN_CLR, 32'h2);
		rd(pdm_mic_pkg::OFF_INTEN_SET, 32'h5);
		wr(pdm_mic_pkg::OFF_INTEN_CLR, 32'h0);
		rd(pdm_mic_pkg::OFF_INTEN_CLR, 32'h5);
		wr(pdm_mic_pkg::OFF_INTEN, 32'h2);
		rd(pdm_mic_pkg::OFF_INTEN_SET, 32'h2);
		wr(pdm_mic_pkg::OFF_CLK_PIN, 32'h80000011);
		wr(pdm_mic_pkg::OFF_DATA_PIN, 32'h7);
		wr(pdm_mic_pkg::OFF_MCLK, 32'h123);
		rd(pdm_mic_pkg::OFF_DATA_PIN, 32'h7);
		chk(data_pin_route, 32'h7);
		chk(mclk_setup, 32'h123);
		wr(pdm_mic_pkg::OFF_GAIN_LEFT, 32'h7f);
		rd(pdm_mic_pkg::OFF_GAIN_LEFT, 32'h50);
		xfer(12'hc00, 1'b0, 32'h0);
		chk({31'h0, e}, 32'h1);
		wr(pdm_mic_pkg::OFF_SAMPLE_BUFFER_POINTER, 32'h2000);
		wr(pdm_mic_pkg::OFF_SAMPLE_COUNT, 32'h4);
		rd(pdm_mic_pkg::OFF_SAMPLE_COUNT, 32'h4);
		// Half-period of 4 cycles gives the 320 ns mic clock
		wr(pdm_mic_pkg::OFF_CLKCTRL, 32'h3);
		wr(pdm_mic_pkg::OFF_ENABLE, 32'h1);
		wr(pdm_mic_pkg::OFF_INTEN_SET, 32'h7);
		// Ten rising mic clock edges in 80 cycles means an 8-cycle period
		pc = pdm_clk_out;
		repeat (80) begin
			@(posedge sys_clk);
			if (pdm_clk_out === 1'b1 && pc === 1'b0) nw++;
			pc = pdm_clk_out;
		end
		chk(32'(nw), 32'h0000000a);
		nw = 0;
		for (int i = 0; i < 5; i++)
			run(i);
		wr(pdm_mic_pkg::OFF_ENABLE, 32'h0);
		wr(pdm_mic_pkg::OFF_TASK_START, 32'h1);
		repeat (700) begin
			@(posedge sys_clk);
			if (dma_wr_en !== 1'b0) nw++;
		end
		chk(32'(nw), 32'h0);
		results();
	end
endmodule // pdm_mic_interface_regs_bench
